// [hw/bgm_battery_gauge.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bgm_regs.svh"

// Function
// - Signed result adds to charge or discharge
// - Count every completed gauge conversion
// - Last gauge result readable, two's complement
// - Read request snapshots accumulators within eight ticks
// - Read request clears itself after transfer
// - Clear bits zero their value, self-clear
// - Clear with read request happens after transfer
// - Gauge calibration shorts converter inputs
// - Gauge conversion spans 8192 slow ticks
// - Gauge disabled by reset, enable resets 0
// - Standby low aborts conversion at once
// - Enable cleared finishes current conversion first
// - Power bit switches voltage monitor on/off
// - Resolution bit picks 7 or 12 bits
// - Ready bit set once converter usable
// - Start bit launches one conversion, self-clears
// - Running high during conversion, result valid after
// - Voltage calibration grounds converter input
// - Voltage conversion 256 or 8192 ticks
// - Voltage monitor disabled by reset
module bgm_battery_gauge #(
   parameter int unsigned GAUGE_CONV_CYCLES = `BGM_GAUGE_CONV_CYCLES,
   parameter int unsigned VMON12_CYCLES     = `BGM_VMON12_CYCLES,
   parameter int unsigned VMON7_CYCLES      = `BGM_VMON7_CYCLES,
   parameter int unsigned VMON_WARM_CYCLES  = `BGM_VMON_WARM_CYCLES
) (
   input  wire logic        clock_in,          // 10 MHz system clock
   input  wire logic        rst_n_in,          // Power-on reset, async
   input  wire logic        rtc_clk_in,        // 32.768 kHz slow clock pin
   input  wire logic        ext_reset_n_in,    // External reset pin
   input  wire logic        standby_n_in,      // Standby pin
   input  wire logic [12:0] gauge_adc_in,      // Gauge converter output
   input  wire logic [11:0] vmon_adc_in,       // Voltage converter output
   input  wire logic        reg_wr_in,         // Register write strobe
   input  wire logic        reg_rd_in,         // Register read strobe
   input  wire logic [7:0]  reg_addr_in,       // Register byte address
   input  wire logic [7:0]  reg_wdata_in,      // Register write data
   output logic      [7:0]  reg_rdata_out,     // Register read data
   output logic             gauge_adc_on_out,  // Gauge converter running
   output logic             gauge_short_out,   // Gauge inputs shorted
   output logic             vmon_adc_on_out,   // Voltage converter powered
   output logic             vmon_ground_out,   // Voltage input grounded
   output logic             vmon_res12_out     // Voltage converter 12-bit mode
);

   // Magnitude of a signed gauge sample, widened for the accumulators
   function automatic logic [23:0] bgm_mag(input logic [12:0] s);
      logic [12:0] m;
      m = s[12] ? (~s + 13'h0001) : s;
      return {11'h000, m};
   endfunction

   // Synchronisers; stage 1 is read only by stage 2
   logic [27:0] sync1_q, sync2_q;               // Slow clock, external reset, standby, converters
   logic        rtc_s2_q, rtc_s3_q, xrst_s2_q, stb_s2_q;
   logic [12:0] gadc_s2_q;                      // Gauge word, second stage
   logic [11:0] vadc_s2_q;                      // Voltage word, second stage
   logic        rtc_tick;                       // One cycle per slow rising edge

   // Two stages per pin; reset low, so a slow clock high at reset release shows one edge
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_q  <= 28'h0000000;
         sync2_q  <= 28'h0000000;
         rtc_s3_q <= 1'b0;
      end else begin
         sync1_q  <= {rtc_clk_in, ext_reset_n_in, standby_n_in, gauge_adc_in, vmon_adc_in};
         sync2_q  <= sync1_q;
         rtc_s3_q <= rtc_s2_q;
      end
   end

   assign {rtc_s2_q, xrst_s2_q, stb_s2_q, gadc_s2_q, vadc_s2_q} = sync2_q;
   assign rtc_tick = rtc_s2_q & ~rtc_s3_q;

   // Gauge state
   bgm_pkg::bgm_gstate_e g_state_q, g_state_d;
   logic [13:0] g_cnt_q, g_cnt_d;               // Slow ticks into conversion
   logic [12:0] g_res_q, g_res_d;               // Last conversion result
   logic [23:0] chg_q, chg_d, dch_q, dch_d;     // Live accumulators
   logic [11:0] cnt_q, cnt_d;                   // Live conversion counter
   logic [23:0] chg_snap_q, chg_snap_d;         // Host-visible copies
   logic [23:0] dch_snap_q, dch_snap_d;
   logic [11:0] cnt_snap_q, cnt_snap_d;
   logic        g_en_q, g_en_d, g_cal_q, g_cal_d;
   logic        rdreq_q, rdreq_d;
   logic        clr_chg_q, clr_chg_d, clr_dch_q, clr_dch_d, clr_cnt_q, clr_cnt_d;
   logic        g_on_q, g_on_d;
   logic        wr_gc, xfer, clr_ok;

   // Gauge next state
   always_comb begin
      g_state_d  = g_state_q;
      g_cnt_d    = g_cnt_q;
      g_res_d    = g_res_q;
      {chg_d, dch_d, cnt_d} = {chg_q, dch_q, cnt_q};
      {chg_snap_d, dch_snap_d, cnt_snap_d} = {chg_snap_q, dch_snap_q, cnt_snap_q};
      {g_en_d, g_cal_d, rdreq_d} = {g_en_q, g_cal_q, rdreq_q};
      {clr_chg_d, clr_dch_d, clr_cnt_d} = {clr_chg_q, clr_dch_q, clr_cnt_q};
      wr_gc      = reg_wr_in && (reg_addr_in == `BGM_REG_GAUGE_CTRL);
      // Transfer lands on the first slow tick, well inside eight ticks
      xfer       = rdreq_q && rtc_tick;
      clr_ok     = !rdreq_q || xfer;
      case (g_state_q)
         bgm_pkg::BGM_G_IDLE: begin
            if (g_en_q && stb_s2_q) begin
               g_state_d = bgm_pkg::BGM_G_CONV;
               g_cnt_d   = 14'h0000;
            end
         end
         bgm_pkg::BGM_G_CONV: begin
            if (!stb_s2_q) begin
               // Standby drops the conversion mid-way, no result kept
               g_state_d = bgm_pkg::BGM_G_IDLE;
               g_cnt_d   = 14'h0000;
            end else if (rtc_tick) begin
               if (g_cnt_q == 14'(GAUGE_CONV_CYCLES - 1)) begin
                  g_cnt_d = 14'h0000;
                  g_res_d = gadc_s2_q;
                  if (gadc_s2_q[12]) begin
                     dch_d = dch_q + bgm_mag(gadc_s2_q);
                  end else begin
                     chg_d = chg_q + bgm_mag(gadc_s2_q);
                  end
                  cnt_d = cnt_q + 12'h001;
                  if (!g_en_q) begin
                     g_state_d = bgm_pkg::BGM_G_IDLE;
                  end
               end else begin
                  g_cnt_d = g_cnt_q + 14'h0001;
               end
            end
         end
         default: begin
            g_state_d = bgm_pkg::BGM_G_IDLE;
         end
      endcase
      // Snapshot takes pre-update values so a clear never hides them
      if (xfer) begin
         chg_snap_d = chg_q;
         dch_snap_d = dch_q;
         cnt_snap_d = cnt_q;
         rdreq_d    = 1'b0;
      end
      // Pending clears wait for the transfer when one is requested
      if (clr_ok && clr_chg_q) begin
         chg_d     = 24'h000000;
         clr_chg_d = 1'b0;
      end
      if (clr_ok && clr_dch_q) begin
         dch_d     = 24'h000000;
         clr_dch_d = 1'b0;
      end
      if (clr_ok && clr_cnt_q) begin
         cnt_d     = 12'h000;
         clr_cnt_d = 1'b0;
      end
      // Host writes; set wins over a same-cycle self-clear
      if (wr_gc) begin
         g_en_d  = reg_wdata_in[`BGM_GC_ENABLE];
         g_cal_d = reg_wdata_in[`BGM_GC_CAL];
         // Writing 0 never cancels a pending request or clear
         rdreq_d   = rdreq_d | reg_wdata_in[`BGM_GC_RDREQ];
         clr_chg_d = clr_chg_d | reg_wdata_in[`BGM_GC_CLR_CHG];
         clr_dch_d = clr_dch_d | reg_wdata_in[`BGM_GC_CLR_DCH];
         clr_cnt_d = clr_cnt_d | reg_wdata_in[`BGM_GC_CLR_CNT];
      end
      // External reset pin holds the gauge off
      if (!xrst_s2_q) begin
         g_state_d = bgm_pkg::BGM_G_IDLE;
         g_cnt_d   = 14'h0000;
         {g_en_d, g_cal_d, rdreq_d, clr_chg_d, clr_dch_d, clr_cnt_d} = 6'h00;
      end
      g_on_d = (g_state_d == bgm_pkg::BGM_G_CONV);
   end

   // Gauge registers
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         g_state_q <= bgm_pkg::BGM_G_IDLE;
         g_cnt_q   <= 14'h0000;
         g_res_q   <= 13'h0000;
         {chg_q, dch_q, cnt_q} <= 60'h0;
         {chg_snap_q, dch_snap_q, cnt_snap_q} <= 60'h0;
         g_en_q    <= 1'(`BGM_GAUGE_CTRL_RST >> `BGM_GC_ENABLE);
         {g_cal_q, rdreq_q, clr_chg_q, clr_dch_q, clr_cnt_q, g_on_q} <= 6'h00;
      end else begin
         g_state_q <= g_state_d;
         g_cnt_q   <= g_cnt_d;
         g_res_q   <= g_res_d;
         {chg_q, dch_q, cnt_q} <= {chg_d, dch_d, cnt_d};
         {chg_snap_q, dch_snap_q, cnt_snap_q} <= {chg_snap_d, dch_snap_d, cnt_snap_d};
         {g_en_q, g_cal_q, rdreq_q} <= {g_en_d, g_cal_d, rdreq_d};
         {clr_chg_q, clr_dch_q, clr_cnt_q, g_on_q} <= {clr_chg_d, clr_dch_d, clr_cnt_d, g_on_d};
      end
   end

   // Voltage monitor state
   bgm_pkg::bgm_vstate_e v_state_q, v_state_d;
   logic [13:0] v_cnt_q, v_cnt_d;               // Slow ticks in warm-up or conversion
   logic        v_pwr_q, v_pwr_d, v_res_q, v_res_d, v_cal_q, v_cal_d;
   logic [11:0] v_data_q, v_data_d;             // Last voltage result
   logic        v_on_q, v_on_d;
   logic        wr_vc;
   logic [13:0] v_last;

   // Voltage monitor next state
   always_comb begin
      v_state_d = v_state_q;
      v_cnt_d   = v_cnt_q;
      {v_pwr_d, v_res_d, v_cal_d} = {v_pwr_q, v_res_q, v_cal_q};
      v_data_d  = v_data_q;
      wr_vc     = reg_wr_in && (reg_addr_in == `BGM_REG_VADC_CTRL);
      v_last    = v_res_q ? 14'(VMON12_CYCLES - 1) : 14'(VMON7_CYCLES - 1);
      case (v_state_q)
         bgm_pkg::BGM_V_OFF: begin
            if (v_pwr_q) begin
               v_state_d = bgm_pkg::BGM_V_WARM;
               v_cnt_d   = 14'h0000;
            end
         end
         bgm_pkg::BGM_V_WARM: begin
            if (rtc_tick) begin
               if (v_cnt_q == 14'(VMON_WARM_CYCLES - 1)) begin
                  v_state_d = bgm_pkg::BGM_V_READY;
               end else begin
                  v_cnt_d = v_cnt_q + 14'h0001;
               end
            end
         end
         bgm_pkg::BGM_V_READY: begin
            // Start is a write pulse; it is never stored so it reads 0
            if (wr_vc && reg_wdata_in[`BGM_VC_START]) begin
               v_state_d = bgm_pkg::BGM_V_RUN;
               v_cnt_d   = 14'h0000;
            end
         end
         bgm_pkg::BGM_V_RUN: begin
            if (rtc_tick) begin
               if (v_cnt_q == v_last) begin
                  // Result lands together with the fall of running
                  v_state_d = bgm_pkg::BGM_V_READY;
                  v_data_d  = v_res_q ? vadc_s2_q : {5'h00, vadc_s2_q[11:5]};
               end else begin
                  v_cnt_d = v_cnt_q + 14'h0001;
               end
            end
         end
         default: begin
            v_state_d = bgm_pkg::BGM_V_OFF;
         end
      endcase
      if (!v_pwr_q) begin
         v_state_d = bgm_pkg::BGM_V_OFF;
      end
      if (wr_vc) begin
         v_pwr_d = reg_wdata_in[`BGM_VC_POWER];
         v_res_d = reg_wdata_in[`BGM_VC_RES12];
         v_cal_d = reg_wdata_in[`BGM_VC_CAL];
      end
      if (!xrst_s2_q) begin
         v_state_d = bgm_pkg::BGM_V_OFF;
         v_pwr_d   = 1'b0;
         v_cal_d   = 1'b0;
      end
      v_on_d = (v_state_d != bgm_pkg::BGM_V_OFF);
   end

   // Voltage monitor registers
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         v_state_q <= bgm_pkg::BGM_V_OFF;
         v_cnt_q   <= 14'h0000;
         {v_pwr_q, v_res_q, v_cal_q} <= 3'h0;
         v_data_q  <= 12'h000;
         v_on_q    <= 1'b0;
      end else begin
         v_state_q <= v_state_d;
         v_cnt_q   <= v_cnt_d;
         {v_pwr_q, v_res_q, v_cal_q} <= {v_pwr_d, v_res_d, v_cal_d};
         v_data_q  <= v_data_d;
         v_on_q    <= v_on_d;
      end
   end

   // Read data, registered on the read strobe and held otherwise
   logic [7:0] rdata_d;                         // Next read data

   always_comb begin
      rdata_d = reg_rdata_out;
      if (reg_rd_in) begin
         if (reg_addr_in == `BGM_REG_GAUGE_CTRL) rdata_d = {1'b0, g_on_q, clr_cnt_q, clr_dch_q,
            clr_chg_q, rdreq_q, g_cal_q, g_en_q};
         else if (reg_addr_in == `BGM_REG_GRES_LO) rdata_d = g_res_q[7:0];
         else if (reg_addr_in == `BGM_REG_GRES_HI) begin
            rdata_d = {{3{g_res_q[12]}}, g_res_q[12:8]};
         end else if (reg_addr_in == `BGM_REG_CHG_B0) rdata_d = chg_snap_q[7:0];
         else if (reg_addr_in == `BGM_REG_CHG_B1) rdata_d = chg_snap_q[15:8];
         else if (reg_addr_in == `BGM_REG_CHG_B2) rdata_d = chg_snap_q[23:16];
         else if (reg_addr_in == `BGM_REG_DCH_B0) rdata_d = dch_snap_q[7:0];
         else if (reg_addr_in == `BGM_REG_DCH_B1) rdata_d = dch_snap_q[15:8];
         else if (reg_addr_in == `BGM_REG_DCH_B2) rdata_d = dch_snap_q[23:16];
         else if (reg_addr_in == `BGM_REG_CNT_LO) rdata_d = cnt_snap_q[7:0];
         else if (reg_addr_in == `BGM_REG_CNT_HI) rdata_d = {4'h0, cnt_snap_q[11:8]};
         else if (reg_addr_in == `BGM_REG_VADC_CTRL) rdata_d = {2'b00,
            v_state_q == bgm_pkg::BGM_V_RUN,
            v_state_q == bgm_pkg::BGM_V_READY || v_state_q == bgm_pkg::BGM_V_RUN,
            1'b0, v_cal_q, v_res_q, v_pwr_q};
         else if (reg_addr_in == `BGM_REG_VRES_LO) rdata_d = v_data_q[7:0];
         else if (reg_addr_in == `BGM_REG_VRES_HI) rdata_d = {4'h0, v_data_q[11:8]};
         else rdata_d = 8'h00;                  // Unmapped places read zero
      end
   end

   // Read data register, driving the port straight from the flop
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         reg_rdata_out <= rdata_d;
      end
   end

   assign gauge_adc_on_out = g_on_q;
   assign gauge_short_out  = g_cal_q;
   assign vmon_adc_on_out  = v_on_q;
   assign vmon_ground_out  = v_cal_q;
   assign vmon_res12_out   = v_res_q;

endmodule

`default_nettype wire

// [hw/bgm_pkg.sv]
package bgm_pkg;

   // Gauge converter sequencing, one-hot
   typedef enum logic [1:0] {
      BGM_G_IDLE = 2'b01,
      BGM_G_CONV = 2'b10
   } bgm_gstate_e;

   // Voltage monitor sequencing, one-hot
   typedef enum logic [3:0] {
      BGM_V_OFF   = 4'b0001,
      BGM_V_WARM  = 4'b0010,
      BGM_V_READY = 4'b0100,
      BGM_V_RUN   = 4'b1000
   } bgm_vstate_e;

endpackage

// [hw/bgm_regs.svh]
`ifndef BGM_REGS_SVH
`define BGM_REGS_SVH

// Register byte offsets on the register port
`define BGM_REG_GAUGE_CTRL   8'h00
`define BGM_REG_GRES_LO      8'h01
`define BGM_REG_GRES_HI      8'h02
`define BGM_REG_CHG_B0       8'h03
`define BGM_REG_CHG_B1       8'h04
`define BGM_REG_CHG_B2       8'h05
`define BGM_REG_DCH_B0       8'h06
`define BGM_REG_DCH_B1       8'h07
`define BGM_REG_DCH_B2       8'h08
`define BGM_REG_CNT_LO       8'h09
`define BGM_REG_CNT_HI       8'h0a
`define BGM_REG_VADC_CTRL    8'h10
`define BGM_REG_VRES_LO      8'h11
`define BGM_REG_VRES_HI      8'h12

// Gauge control field positions
`define BGM_GC_ENABLE        0
`define BGM_GC_CAL           1
`define BGM_GC_RDREQ         2
`define BGM_GC_CLR_CHG       3
`define BGM_GC_CLR_DCH       4
`define BGM_GC_CLR_CNT       5
`define BGM_GC_ACTIVE        6

// Voltage ADC control field positions
`define BGM_VC_POWER         0
`define BGM_VC_RES12         1
`define BGM_VC_CAL           2
`define BGM_VC_START         3
`define BGM_VC_READY         4
`define BGM_VC_RUN           5

// Reset values
`define BGM_GAUGE_CTRL_RST   8'h00
`define BGM_VADC_CTRL_RST    8'h00

// Timing; the cycle counts are in slow clock periods
`define BGM_RTC_HZ           32768
`define BGM_GAUGE_CONV_MS    250
`define BGM_GAUGE_CONV_CYCLES (`BGM_GAUGE_CONV_MS * `BGM_RTC_HZ / 1000)
`define BGM_VMON7_CYCLES     256
`define BGM_VMON12_CYCLES    8192
`define BGM_VMON_WARM_CYCLES 4

`endif

// [tb/bgm_battery_gauge_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module bgm_battery_gauge_monitor #(
   parameter int unsigned GAUGE_CONV_CYCLES = 8192
) (
   input wire logic       clock_in,
   input wire logic       rst_n_in,
   input wire logic       ext_reset_n_in,
   input wire logic       standby_n_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       gauge_adc_on_out,
   input wire logic       gauge_short_out,
   input wire logic       vmon_adc_on_out,
   input wire logic       vmon_ground_out,
   input wire logic       vmon_res12_out
);
   logic [15:0] on_cnt_q;  // Cycles the gauge has been converting
   logic [15:0] on_cnt_d;  // Next value of the run counter
   logic        w0;        // Write to gauge control
   logic        w10;       // Write to voltage control
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   assign w0  = reg_wr_in && (reg_addr_in == 8'h00);
   assign w10 = reg_wr_in && (reg_addr_in == 8'h10);
   // Saturate so a long run never wraps into a short one
   always_comb begin
      on_cnt_d = 16'h0000;
      if (gauge_adc_on_out) begin
         on_cnt_d = (on_cnt_q == 16'hffff) ? on_cnt_q : on_cnt_q + 16'h0001;
      end
   end
   // Run counter register
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         on_cnt_q <= 16'h0000;
      end else begin
         on_cnt_q <= on_cnt_d;
      end
   end
   // Writes are trusted only once the external reset has settled, except in the two vmon power checks
   a_gcal_follow: assert property ((w0 && ext_reset_n_in && $past(ext_reset_n_in, 4)) ##1 !w0
      |-> ##1 gauge_short_out == $past(reg_wdata_in[1], 2)) else $error("gauge short wrong");
   a_vcal_follow: assert property ((w10 && ext_reset_n_in && $past(ext_reset_n_in, 4)) ##1 !w10
      |-> ##1 vmon_ground_out == $past(reg_wdata_in[2], 2)) else $error("vmon ground wrong");
   a_res_follow: assert property ((w10 && ext_reset_n_in && $past(ext_reset_n_in, 4)) ##1 !w10
      |-> ##1 vmon_res12_out == $past(reg_wdata_in[1], 2)) else $error("resolution wrong");
   a_vpower_on: assert property ((w10 && reg_wdata_in[0] && ext_reset_n_in) ##1 !w10
      |-> ##[1:3] vmon_adc_on_out) else $error("vmon did not power up");
   a_vpower_off: assert property ((w10 && !reg_wdata_in[0]) ##1 !w10
      |-> ##1 !vmon_adc_on_out) else $error("vmon did not power down");
   a_gauge_start: assert property ((w0 && reg_wdata_in[0] && ext_reset_n_in
      && $past(ext_reset_n_in, 4) && standby_n_in && $past(standby_n_in, 4)) ##1 !w0
      |-> ##[0:3] gauge_adc_on_out) else $error("gauge did not start");
   a_ext_off: assert property (!ext_reset_n_in [*6] |-> !gauge_adc_on_out && !vmon_adc_on_out
      && !gauge_short_out && !vmon_ground_out) else $error("not disabled in reset");
   a_stby_abort: assert property (!standby_n_in [*6] |-> !gauge_adc_on_out)
      else $error("standby did not stop gauge");
   a_conv_len: assert property ($fell(gauge_adc_on_out) && standby_n_in && $past(standby_n_in, 5)
      && ext_reset_n_in && $past(ext_reset_n_in, 5)
      |-> $past(on_cnt_q) >= (GAUGE_CONV_CYCLES - 1) * 8) else $error("conversion cut short");
   a_rdata_hold: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
      else $error("read data moved without read");
endmodule
bind bgm_battery_gauge bgm_battery_gauge_monitor #(.GAUGE_CONV_CYCLES(GAUGE_CONV_CYCLES))
   bgm_battery_gauge_monitor_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
   .ext_reset_n_in(ext_reset_n_in), .standby_n_in(standby_n_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .gauge_adc_on_out(gauge_adc_on_out),
   .gauge_short_out(gauge_short_out), .vmon_adc_on_out(vmon_adc_on_out),
   .vmon_ground_out(vmon_ground_out), .vmon_res12_out(vmon_res12_out));
`default_nettype wire

// [tb/bgm_battery_gauge_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module bgm_battery_gauge_tb_top;
   typedef struct packed {
      logic [12:0] adc;  // Converter word for the conversion
      logic [7:0]  ctl;  // Gauge control written to start it
      logic [23:0] chg;  // Charge total after it
      logic [23:0] dch;  // Discharge total after it
      logic [23:0] cnt;  // Conversions after it
   } bgm_row_s;
   logic        clock_in, rst_n_in, rtc_clk_in, ext_reset_n_in, standby_n_in;
   logic [12:0] gauge_adc_in;
   logic [11:0] vmon_adc_in;
   logic        reg_wr_in, reg_rd_in;
   logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, b;
   logic        gauge_adc_on_out, gauge_short_out, vmon_adc_on_out, vmon_ground_out;
   logic        vmon_res12_out;
   logic [23:0] v;
   int          n_errors, cmp_count, n;
   // Zero result counts as charge; negative adds its magnitude
   bgm_row_s    rows [5] = '{
      '{13'h0005, 8'h01, 24'h000005, 24'h000000, 24'h000001},
      '{13'h1ffd, 8'h03, 24'h000005, 24'h000003, 24'h000002},
      '{13'h0000, 8'h01, 24'h000005, 24'h000003, 24'h000003},
      '{13'h0fff, 8'h01, 24'h001004, 24'h000003, 24'h000004},
      '{13'h1000, 8'h01, 24'h001004, 24'h001003, 24'h000005}};
   // Counts shortened so a conversion is 16 slow ticks
   bgm_battery_gauge #(.GAUGE_CONV_CYCLES(16), .VMON12_CYCLES(16), .VMON7_CYCLES(8),
      .VMON_WARM_CYCLES(2)) bgm_battery_gauge_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .rtc_clk_in(rtc_clk_in), .ext_reset_n_in(ext_reset_n_in), .standby_n_in(standby_n_in),
      .gauge_adc_in(gauge_adc_in), .vmon_adc_in(vmon_adc_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .gauge_adc_on_out(gauge_adc_on_out),
      .gauge_short_out(gauge_short_out), .vmon_adc_on_out(vmon_adc_on_out),
      .vmon_ground_out(vmon_ground_out), .vmon_res12_out(vmon_res12_out));
   bgm_host_model bgm_host_model_inst (.clock_in(clock_in), .rdata_in(reg_rdata_out),
      .wr_out(reg_wr_in), .rd_out(reg_rd_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
   // System clock, 100 ns
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end
   // Slow clock, 800 ns, phase unrelated to the system clock
   initial begin
      rtc_clk_in = 1'b0;
      #137;
      forever #400 rtc_clk_in = ~rtc_clk_in;
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   // Little-endian multi-byte read
   task automatic rdn(input logic [7:0] a, input int cnt, output logic [23:0] val);
      val = 24'h000000;
      for (int j = 0; j < cnt; j++) begin
         bgm_host_model_inst.rd(a + 8'(j), b);
         val[8*j+:8] = b;
      end
   endtask
   // Snapshot, then compare all three totals
   task automatic totals(input logic [7:0] ctl, input logic [23:0] c, d, k);
      bgm_host_model_inst.snap(ctl);
      rdn(8'h03, 3, v);
      chk("charge", c, v);
      rdn(8'h06, 3, v);
      chk("discharge", d, v);
      rdn(8'h09, 2, v);
      chk("count", k, v);
   endtask
   // Poll one voltage control bit; n counts cycles spent
   task automatic poll(input int bn, input logic val);
      for (n = 0; n < 400; n += 3) begin
         bgm_host_model_inst.rd(8'h10, b);
         if (b[bn] === val) break;
      end
      if (n >= 400) begin
         n_errors++;
         print_verdict();
      end
   endtask
   initial begin
      rst_n_in = 1'b0;
      ext_reset_n_in = 1'b1;
      standby_n_in = 1'b1;
      gauge_adc_in = 13'h0000;
      vmon_adc_in = 12'habc;
      repeat (16) @(posedge clock_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      // Every place reads zero after reset, unmapped ones too
      for (int a = 0; a <= 32; a++) begin
         bgm_host_model_inst.rd(8'(a), b);
         chk("reset value", 24'h000000, {16'h0000, b});
      end
      bgm_host_model_inst.wr(8'h20, 8'hff);
      bgm_host_model_inst.rd(8'h20, b);
      chk("unmapped", 24'h000000, {16'h0000, b});
      // One conversion per row: enable is dropped mid-conversion
      foreach (rows[i]) begin
         gauge_adc_in <= rows[i].adc;
         bgm_host_model_inst.wr(8'h00, rows[i].ctl);
         repeat (4) @(posedge clock_in);
         chk("short", {23'h0, rows[i].ctl[1]}, {23'h0, gauge_short_out});
         bgm_host_model_inst.wr(8'h00, rows[i].ctl & 8'hfe);
         for (n = 0; n < 400 && gauge_adc_on_out !== 1'b0; n++) @(posedge clock_in);
         chk("finished", 24'h000001, {23'h0, n >= 100});
         rdn(8'h01, 2, v);
         chk("last result", {8'h0, {3{rows[i].adc[12]}}, rows[i].adc}, v);
         totals(8'h04, rows[i].chg, rows[i].dch, rows[i].cnt);
      end
      // Clears with read request land after the copy
      totals(8'h3c, 24'h001004, 24'h001003, 24'h000005);
      totals(8'h04, 24'h000000, 24'h000000, 24'h000000);
      bgm_host_model_inst.rd(8'h00, b);
      chk("self clear", 24'h000000, {16'h0000, b});
      // Standby abandons a conversion with nothing recorded
      bgm_host_model_inst.wr(8'h00, 8'h01);
      repeat (10) @(posedge clock_in);
      standby_n_in <= 1'b0;
      repeat (10) @(posedge clock_in);
      chk("standby stop", 24'h000000, {23'h0, gauge_adc_on_out});
      bgm_host_model_inst.wr(8'h00, 8'h00);
      standby_n_in <= 1'b1;
      repeat (200) @(posedge clock_in);
      totals(8'h04, 24'h000000, 24'h000000, 24'h000000);
      // Voltage monitor, 7-bit then 12-bit
      bgm_host_model_inst.wr(8'h10, 8'h01);
      poll(4, 1'b1);
      chk("vmon on", 24'h000001, {23'h0, vmon_adc_on_out});
      bgm_host_model_inst.wr(8'h10, 8'h09);
      bgm_host_model_inst.rd(8'h10, b);
      chk("start run", 24'h000002, {22'h0, b[5], b[3]});
      poll(5, 1'b0);
      chk("7 bit time", 24'h000001, {23'h0, n >= 40 && n < 100});
      rdn(8'h11, 2, v);
      chk("7 bit result", 24'h000055, v);
      bgm_host_model_inst.wr(8'h10, 8'h03);
      bgm_host_model_inst.wr(8'h10, 8'h0b);
      poll(5, 1'b0);
      chk("12 bit time", 24'h000001, {23'h0, n >= 100 && n < 170});
      rdn(8'h11, 2, v);
      chk("12 bit result", 24'h000abc, v);
      bgm_host_model_inst.wr(8'h10, 8'h05);
      repeat (3) @(posedge clock_in);
      chk("ground", 24'h000001, {23'h0, vmon_ground_out});
      // Start written together with power off ends with the monitor off
      bgm_host_model_inst.wr(8'h10, 8'h08);
      bgm_host_model_inst.rd(8'h10, b);
      chk("start off", 24'h000000, {15'h0, vmon_adc_on_out, b});
      // External reset disables both functions
      bgm_host_model_inst.wr(8'h00, 8'h03);
      bgm_host_model_inst.wr(8'h10, 8'h05);
      ext_reset_n_in <= 1'b0;
      repeat (10) @(posedge clock_in);
      ext_reset_n_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      rdn(8'h00, 1, v);
      chk("gauge ctrl", 24'h000000, v);
      rdn(8'h10, 1, v);
      chk("vmon ctrl", 24'h000000, v);
      print_verdict();
   end
endmodule
`default_nettype wire

// [tb/bgm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bgm_host_model (
   input  wire logic       clock_in,
   input  wire logic [7:0] rdata_in,
   output logic            wr_out,
   output logic            rd_out,
   output logic      [7:0] addr_out,
   output logic      [7:0] wdata_out
);
   // Idle bus at time zero
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end
   // One-cycle write strobe; a gap cycle follows so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      wr_out <= 1'b1;
      addr_out <= a;
      wdata_out <= d;
      @(posedge clock_in);
      wr_out <= 1'b0;
   endtask
   // Read data is a register, so take it one edge after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_in);
      rd_out <= 1'b1;
      addr_out <= a;
      @(posedge clock_in);
      rd_out <= 1'b0;
      @(posedge clock_in);
      #1 d = rdata_in;
   endtask
   // Snapshot request, then the settle time before any snapshot read
   task automatic snap(input logic [7:0] ctl);
      wr(8'h00, ctl);
      repeat (80) @(posedge clock_in);
   endtask
endmodule
`default_nettype wire
